// *** shared/mic_pkg.sv ***
// Constants and carrier types of the interrupt control block
package mic_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CORE_CTL = 8'h0B;
    localparam logic [7:0] IDX_CORE_CTL_ALIAS = 8'h8B;
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PORT_VALUE = 8'h40;
    localparam logic [7:0] IDX_PIN_CHANGE_EN = 8'h41;
    localparam logic [7:0] IDX_EDGE_SELECT = 8'h42;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_GROUP_EN = 6;
    localparam int BIT_TIMER0_EN = 5;
    localparam int BIT_EXT_PIN_EN = 4;
    localparam int BIT_PIN_CHANGE_EN = 3;
    localparam int BIT_TIMER0_FLAG = 2;
    localparam int BIT_EXT_PIN_FLAG = 1;
    localparam int BIT_PIN_CHANGE_FLAG = 0;
    localparam int BIT_NVM_DONE = 7;
    localparam int BIT_CONV_DONE = 6;
    localparam int BIT_COMPARATOR = 3;
    localparam int BIT_TIMER1 = 0;

    // ------------------------------------------------------------
    // Widths, masks and reset values
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 6;
    localparam int PC_WIDTH = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam logic [7:0] PERIPH_IMPL_MASK = 8'hC9;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [9:0] paddr;
        logic [31:0] pwdata;
    } mic_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } mic_apb_rsp_t;

    typedef struct packed {
        logic timer0Overflow;
        logic timer1Overflow;
        logic nvmWriteDone;
        logic conversionDone;
        logic comparatorChange;
    } mic_events_t;

endpackage : mic_pkg

// *** core/mic_interrupt_control.sv ***
// Interrupt enable, flag and request logic with return stack
`timescale 1ns/1ps
// Behaviour
// - Global enable bit 7 gates all interrupts
// - Bit 6 gates the peripheral interrupt group
// - Bit 5 enables the timer0 overflow interrupt
// - Bit 4 enables the external pin interrupt
// - Bit 3 plus per-pin enable gates pin change
// - Bit 2 sets on timer0 rollover, sticky
// - Bit 1 sets on external pin event, sticky
// - Bit 0 sets on a change of a pin with its per-pin enable set, sticky
// - Flags set regardless of the control and peripheral enable bits
// - Control register reachable at both bank addresses
// - Peripheral enables at bits 7, 6, 3, 0
// - Peripheral interrupts also need the group enable
// - Unused peripheral bits always read zero
// - Peripheral flag 7 sets on write done
// - Peripheral flag 6 sets on conversion done
// - Peripheral flag 3 sets on comparator change
// - Peripheral flag 0 sets on timer1 overflow
// - Accepted interrupt pushes program counter onto stack
// - Pin change ORs enabled mismatches against last port access
// - Edge select picks rising or falling pin edge
module mic_interrupt_control (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register bus
    input wire mic_pkg::mic_apb_req_t apbReq,
    output mic_pkg::mic_apb_rsp_t apbRsp,
    // Peripheral events, one-cycle pulses
    input wire mic_pkg::mic_events_t events,
    // Pins
    input wire logic externalIrqPin,
    input wire logic [mic_pkg::PIN_COUNT-1:0] portPins,
    // Processor core
    input wire logic irqTaken,
    input wire logic [mic_pkg::PC_WIDTH-1:0] programCounter,
    input wire logic stackPop,
    output logic irqRequest,
    output logic [mic_pkg::PC_WIDTH-1:0] stackTop
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] coreCtl;
        logic [7:0] periphFlags;
        logic [7:0] periphEnables;
        logic [mic_pkg::PIN_COUNT-1:0] pinChangeEnable;
        logic edgeSelect;
        logic [mic_pkg::PIN_COUNT-1:0] portLatch;
        logic [mic_pkg::PIN_COUNT-1:0] pinSync1;
        logic [mic_pkg::PIN_COUNT-1:0] pinSync2;
        logic extSync1;
        logic extSync2;
        logic extPrev;
        logic [mic_pkg::STACK_PTR_W-1:0] stackPtr;
        logic [mic_pkg::STACK_DEPTH-1:0][mic_pkg::PC_WIDTH-1:0] stack;
        logic [mic_pkg::PC_WIDTH-1:0] stackTop;
        logic irqRequest;
        mic_pkg::mic_apb_rsp_t rsp;
    } mic_state_t;

    mic_state_t state;
    mic_state_t next_state;

    logic [7:0] regIndex;
    logic accessDone;
    logic writeDone;
    logic readDone;
    logic ctlHit;
    logic pinMismatch;
    logic [mic_pkg::PIN_COUNT-1:0] pinDiffer;
    logic extEdge;

    assign regIndex = apbReq.paddr[9:2];
    assign accessDone = apbReq.psel && apbReq.penable && state.rsp.pready;
    assign writeDone = accessDone && apbReq.pwrite;
    assign readDone = accessDone && !apbReq.pwrite;
    assign ctlHit = (regIndex == mic_pkg::IDX_CORE_CTL) ||
                    (regIndex == mic_pkg::IDX_CORE_CTL_ALIAS);

    for (genvar p = 0; p < mic_pkg::PIN_COUNT; p++) begin : g_pin
        assign pinDiffer[p] = state.pinChangeEnable[p] &&
                              (state.pinSync2[p] != state.portLatch[p]);
    end
    assign pinMismatch = |pinDiffer;
    assign extEdge = state.edgeSelect ? (state.extSync2 && !state.extPrev)
                                      : (!state.extSync2 && state.extPrev);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Pin synchronisers
        next_state.pinSync1 = portPins;
        next_state.pinSync2 = state.pinSync1;
        next_state.extSync1 = externalIrqPin;
        next_state.extSync2 = state.extSync1;
        next_state.extPrev = state.extSync2;

        // APB handshake, one wait cycle
        next_state.rsp.pready = apbReq.psel && apbReq.penable && !state.rsp.pready;
        next_state.rsp.pslverr = 1'b0;
        next_state.rsp.prdata = 32'h0000_0000;

        if (writeDone) begin
            if (ctlHit) begin
                next_state.coreCtl = apbReq.pwdata[7:0];
            end
            if (regIndex == mic_pkg::IDX_PERIPH_FLAGS) begin
                next_state.periphFlags = apbReq.pwdata[7:0] & mic_pkg::PERIPH_IMPL_MASK;
            end
            if (regIndex == mic_pkg::IDX_PERIPH_ENABLES) begin
                next_state.periphEnables = apbReq.pwdata[7:0] & mic_pkg::PERIPH_IMPL_MASK;
            end
            if (regIndex == mic_pkg::IDX_PIN_CHANGE_EN) begin
                next_state.pinChangeEnable = apbReq.pwdata[mic_pkg::PIN_COUNT-1:0];
            end
            if (regIndex == mic_pkg::IDX_EDGE_SELECT) begin
                next_state.edgeSelect = apbReq.pwdata[0];
            end
        end

        // Port access ends the mismatch
        if (accessDone && regIndex == mic_pkg::IDX_PORT_VALUE) begin
            next_state.portLatch = state.pinSync2;
        end

        // Read data and error answer
        if (apbReq.psel && apbReq.penable && !state.rsp.pready) begin
            if (ctlHit) begin
                next_state.rsp.prdata = {24'h00_0000, state.coreCtl};
            end else if (regIndex == mic_pkg::IDX_PERIPH_FLAGS) begin
                next_state.rsp.prdata = {24'h00_0000, state.periphFlags};
            end else if (regIndex == mic_pkg::IDX_PERIPH_ENABLES) begin
                next_state.rsp.prdata = {24'h00_0000, state.periphEnables};
            end else if (regIndex == mic_pkg::IDX_PORT_VALUE) begin
                next_state.rsp.prdata = {26'h000_0000, state.pinSync2};
            end else if (regIndex == mic_pkg::IDX_PIN_CHANGE_EN) begin
                next_state.rsp.prdata = {26'h000_0000, state.pinChangeEnable};
            end else if (regIndex == mic_pkg::IDX_EDGE_SELECT) begin
                next_state.rsp.prdata = {31'h0000_0000, state.edgeSelect};
            end else begin
                next_state.rsp.pslverr = 1'b1;
            end
        end

        // events set flags whatever the control and peripheral enable bits
        if (events.timer0Overflow) begin
            next_state.coreCtl[mic_pkg::BIT_TIMER0_FLAG] = 1'b1;
        end
        if (extEdge) begin
            next_state.coreCtl[mic_pkg::BIT_EXT_PIN_FLAG] = 1'b1;
        end
        if (pinMismatch) begin
            next_state.coreCtl[mic_pkg::BIT_PIN_CHANGE_FLAG] = 1'b1;
        end
        if (events.nvmWriteDone) begin
            next_state.periphFlags[mic_pkg::BIT_NVM_DONE] = 1'b1;
        end
        if (events.conversionDone) begin
            next_state.periphFlags[mic_pkg::BIT_CONV_DONE] = 1'b1;
        end
        if (events.comparatorChange) begin
            next_state.periphFlags[mic_pkg::BIT_COMPARATOR] = 1'b1;
        end
        if (events.timer1Overflow) begin
            next_state.periphFlags[mic_pkg::BIT_TIMER1] = 1'b1;
        end

        next_state.irqRequest = next_state.coreCtl[mic_pkg::BIT_GLOBAL_EN] && (
            (next_state.coreCtl[mic_pkg::BIT_TIMER0_EN] &&
             next_state.coreCtl[mic_pkg::BIT_TIMER0_FLAG]) ||
            (next_state.coreCtl[mic_pkg::BIT_EXT_PIN_EN] &&
             next_state.coreCtl[mic_pkg::BIT_EXT_PIN_FLAG]) ||
            (next_state.coreCtl[mic_pkg::BIT_PIN_CHANGE_EN] &&
             next_state.coreCtl[mic_pkg::BIT_PIN_CHANGE_FLAG]) ||
            (next_state.coreCtl[mic_pkg::BIT_PERIPH_GROUP_EN] &&
             |(next_state.periphFlags & next_state.periphEnables)));

        if (irqTaken) begin
            next_state.stack[state.stackPtr] = programCounter;
            next_state.stackPtr = state.stackPtr + 3'h1;
        end else if (stackPop) begin
            next_state.stackPtr = state.stackPtr - 3'h1;
        end
        next_state.stackTop = next_state.stack[next_state.stackPtr - 3'h1];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign apbRsp = state.rsp;
    assign irqRequest = state.irqRequest;
    assign stackTop = state.stackTop;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic ctlWrite;
    logic flagWrite;
    assign ctlWrite = writeDone && ctlHit;
    assign flagWrite = writeDone && regIndex == mic_pkg::IDX_PERIPH_FLAGS;

    a_global_gate: assert property (!state.coreCtl[7] |-> !irqRequest)
        else $error("request raised with global enable clear");

    a_periph_gate: assert property (
        (!state.coreCtl[6] && !(|(state.coreCtl[5:3] & state.coreCtl[2:0])))
        |-> !irqRequest)
        else $error("peripheral request passed without group enable");

    a_timer0_flag: assert property (
        events.timer0Overflow |=> state.coreCtl[2] ##1 (state.coreCtl[2] || $past(ctlWrite)))
        else $error("timer0 flag not set on rollover");

    a_flag_sticky: assert property (
        state.coreCtl[1] && !ctlWrite |=> state.coreCtl[1])
        else $error("external pin flag dropped without software");

    a_pin_change: assert property (pinMismatch |=> state.coreCtl[0])
        else $error("pin change flag not set on mismatch");

    a_alias_write: assert property (
        writeDone && regIndex == mic_pkg::IDX_CORE_CTL_ALIAS
        |=> state.coreCtl[7:3] == $past(apbReq.pwdata[7:3]))
        else $error("alias write did not reach control register");

    a_unused_zero: assert property (
        (state.periphFlags & ~mic_pkg::PERIPH_IMPL_MASK) == 8'h00 &&
        (state.periphEnables & ~mic_pkg::PERIPH_IMPL_MASK) == 8'h00)
        else $error("unimplemented peripheral bit set");

    a_nvm_flag: assert property (events.nvmWriteDone |=> state.periphFlags[7])
        else $error("write done flag not set");

    a_timer1_flag: assert property (events.timer1Overflow |=> state.periphFlags[0])
        else $error("timer1 flag not set");

    a_stack_push: assert property (
        irqTaken |=> state.stackPtr == $past(state.stackPtr) + 3'h1 &&
        stackTop == $past(programCounter))
        else $error("program counter not pushed");

    a_edge_flag: assert property (
        extEdge |=> state.coreCtl[1])
        else $error("external edge not flagged");

    a_apb_wait: assert property (
        apbReq.psel && apbReq.penable && !state.rsp.pready |=> state.rsp.pready)
        else $error("bus answer late");

    // ------------------------------------------------------------
    // Source gates, flag hold and bus answer
    // ------------------------------------------------------------

    a_request_exact: assert property (
        irqRequest == (state.coreCtl[7] &&
            ((|(state.coreCtl[5:3] & state.coreCtl[2:0])) ||
             (state.coreCtl[6] && (|(state.periphFlags & state.periphEnables))))))
        else $error("request differs from enabled flags");

    a_group_pass: assert property (
        state.coreCtl[7] && state.coreCtl[6] &&
        (|(state.periphFlags & state.periphEnables)) |-> irqRequest)
        else $error("enabled peripheral flag did not request");

    a_timer0_pass: assert property (
        state.coreCtl[7] && state.coreCtl[5] && state.coreCtl[2] |-> irqRequest)
        else $error("enabled timer0 flag did not request");

    a_ext_pass: assert property (
        state.coreCtl[7] && state.coreCtl[4] && state.coreCtl[1] |-> irqRequest)
        else $error("enabled external flag did not request");

    a_change_pass: assert property (
        state.coreCtl[7] && state.coreCtl[3] && state.coreCtl[0] |-> irqRequest)
        else $error("enabled pin change flag did not request");

    a_timer0_sticky: assert property (
        state.coreCtl[2] && !ctlWrite |=> state.coreCtl[2])
        else $error("timer0 flag dropped without software");

    a_change_sticky: assert property (
        state.coreCtl[0] && !ctlWrite |=> state.coreCtl[0])
        else $error("pin change flag dropped without software");

    a_nvm_sticky: assert property (
        state.periphFlags[7] && !flagWrite |=> state.periphFlags[7])
        else $error("write done flag dropped without software");

    a_conv_flag: assert property (
        events.conversionDone |=> state.periphFlags[6])
        else $error("conversion flag not set");

    a_cmp_flag: assert property (
        events.comparatorChange |=> state.periphFlags[3])
        else $error("comparator flag not set");

    a_timer1_sticky: assert property (
        state.periphFlags[0] && !flagWrite |=> state.periphFlags[0])
        else $error("timer1 flag dropped without software");

    a_port_latch: assert property (
        accessDone && regIndex == mic_pkg::IDX_PORT_VALUE
        |=> state.portLatch == $past(state.pinSync2))
        else $error("port access did not latch pins");

    a_flag_write: assert property (
        flagWrite |=> (state.periphFlags & $past(apbReq.pwdata[7:0])) ==
        ($past(apbReq.pwdata[7:0]) & mic_pkg::PERIPH_IMPL_MASK))
        else $error("written flag bits did not land");

    a_enable_write: assert property (
        writeDone && regIndex == mic_pkg::IDX_PERIPH_ENABLES |=> state.periphEnables ==
        ($past(apbReq.pwdata[7:0]) & mic_pkg::PERIPH_IMPL_MASK))
        else $error("peripheral enables not written");

    a_read_data: assert property (
        readDone && ctlHit |-> state.rsp.prdata == {24'h00_0000, $past(state.coreCtl)})
        else $error("control read returned wrong data");

    a_stack_pop: assert property (
        stackPop && !irqTaken |=> state.stackPtr == $past(state.stackPtr) - 3'h1)
        else $error("return did not pop");

    a_pointer_hold: assert property (
        !irqTaken && !stackPop |=> state.stackPtr == $past(state.stackPtr))
        else $error("stack pointer moved without push or pop");

    a_error_with_ready: assert property (
        state.rsp.pslverr |-> state.rsp.pready)
        else $error("error answer outside access");

    a_idle_quiet: assert property (
        !state.rsp.pready |-> state.rsp.prdata == 32'h0000_0000 && !state.rsp.pslverr)
        else $error("bus answer outside access");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------

    c_timer0_irq: cover property (events.timer0Overflow ##[1:20] irqRequest);
    c_periph_irq: cover property (events.comparatorChange ##1 irqRequest);
    c_push_pop: cover property (irqTaken ##[1:20] stackPop);
    c_bad_addr: cover property (accessDone && state.rsp.pslverr);
    c_pin_irq: cover property (pinMismatch ##1 irqRequest);

endmodule : mic_interrupt_control

// *** verification/mic_core_model.sv ***
// Processor core model that takes interrupt requests and supplies the program counter to push
`timescale 1ns/1ps
module mic_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bench control
    input wire logic acceptEn,
    input wire logic slow,
    // Interrupt handshake
    input wire logic irqRequest,
    output logic irqTaken,
    output logic [mic_pkg::PC_WIDTH-1:0] programCounter
);
    logic took;
    logic [1:0] waitCnt;
    always @(posedge mclk) begin
        if (reset) begin
            irqTaken <= 1'b0;
            took <= 1'b0;
            waitCnt <= 2'h0;
            programCounter <= 13'h0100;
        end else begin
            // Address never holds still
            programCounter <= programCounter + 13'h0A7;
            if (!acceptEn) begin
                irqTaken <= 1'b0;
                took <= 1'b0;
                waitCnt <= 2'h0;
            end else if (irqRequest && !took && (!slow || waitCnt == 2'h3)) begin
                irqTaken <= 1'b1;
                took <= 1'b1;
            end else begin
                irqTaken <= 1'b0;
                if (irqRequest && !took) begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
        end
    end
endmodule : mic_core_model

// *** verification/mic_interrupt_control_bench.sv ***
// Self-checking bench of the interrupt control block
`timescale 1ns/1ps
module mic_interrupt_control_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    mic_pkg::mic_apb_req_t req = '0;
    mic_pkg::mic_apb_rsp_t rsp;
    mic_pkg::mic_events_t ev = '0;
    logic extPin = 1'b0;
    logic [5:0] pins = 6'h00;
    logic stackPop = 1'b0;
    logic acceptEn = 1'b0;
    logic slow = 1'b0;
    logic irqTaken;
    logic irqRequest;
    logic [12:0] pc;
    logic [12:0] stackTop;
    logic [31:0] rv;
    logic re;
    logic [31:0] lfsr = 32'hFC35;
    logic [23:0] v;
    logic [12:0] pushed [9];
    logic [4:0] evk [5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h10};
    logic [7:0] flk [5] = '{8'h01, 8'h80, 8'h40, 8'h08, 8'h00};
    logic [23:0] corner [4] = '{24'hC9C980, 24'hC9C9C0, 24'h01017F, 24'h0000A4};
    int n_fail = 0;
    int checks = 0;
    int waitN;

    always #4 mclk = ~mclk;

    mic_interrupt_control dut (.mclk(mclk), .reset(reset), .apbReq(req), .apbRsp(rsp),
        .events(ev), .externalIrqPin(extPin), .portPins(pins), .irqTaken(irqTaken),
        .programCounter(pc), .stackPop(stackPop), .irqRequest(irqRequest),
        .stackTop(stackTop));
    mic_core_model core (.mclk(mclk), .reset(reset), .acceptEn(acceptEn), .slow(slow),
        .irqRequest(irqRequest), .irqTaken(irqTaken), .programCounter(pc));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    function automatic logic irq_exp(input logic [7:0] c, input logic [7:0] e,
                                     input logic [7:0] f);
        return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & (|(e & f & mic_pkg::PERIPH_IMPL_MASK))));
    endfunction : irq_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= {24'h0, wd};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (rsp.pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_fail++;
                tally_and_finish();
            end
            @(posedge mclk);
        end
        rv = rsp.prdata;
        re = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic expect_reg(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rv, exp);
    endtask : expect_reg
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    initial begin
        tick(5);
        reset <= 1'b0;
        expect_reg(8'h0B, 32'h0);
        expect_reg(8'h0C, 32'h0);
        expect_reg(8'h8C, 32'h0);
        wr(8'h8B, 8'h5A);
        expect_reg(8'h0B, 32'h5A);
        wr(8'h0B, 8'h00);
        expect_reg(8'h8B, 32'h00);
        wr(8'h8C, 8'hFF);
        expect_reg(8'h8C, 32'hC9);
        wr(8'h0C, 8'hFF);
        expect_reg(8'h0C, 32'hC9);
        apb(1'b0, 8'h33, 8'h00);
        check({rv[30:0], re}, 32'h1);
        $display("test registers done");
        wr(8'h8C, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr(8'h0C, 8'h00);
            wr(8'h0B, 8'h00);
            ev <= evk[k];
            @(posedge mclk);
            ev <= '0;
            expect_reg(8'h0C, {24'h0, flk[k]});
            expect_reg(8'h0B, {29'h0, evk[k][4], 2'b00});
            check({31'h0, irqRequest}, 32'h0);
        end
        $display("test events done");
        for (int i = 0; i < 44; i++) begin
            lfsr = next_rand(lfsr);
            v = (i < 4) ? corner[i] : lfsr[23:0];
            wr(8'h8C, v[15:8]);
            wr(8'h0C, v[23:16]);
            wr(8'h0B, v[7:0]);
            expect_reg(8'h0C, {24'h0, v[23:16] & 8'hC9});
            check({31'h0, irqRequest}, {31'h0, irq_exp(v[7:0], v[15:8], v[23:16])});
        end
        $display("test request done");
        wr(8'h8C, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h42, (k < 2) ? 8'h01 : 8'h00);
            wr(8'h0B, 8'h00);
            extPin <= ~extPin;
            tick(6);
            expect_reg(8'h0B, (k == 0 || k == 3) ? 32'h02 : 32'h00);
        end
        $display("test edge done");
        wr(8'h41, 8'h05);
        apb(1'b0, 8'h40, 8'h00);
        wr(8'h0B, 8'h88);
        pins <= 6'h02;
        tick(6);
        expect_reg(8'h0B, 32'h88);
        check({31'h0, irqRequest}, 32'h0);
        pins <= 6'h06;
        tick(6);
        expect_reg(8'h0B, 32'h89);
        check({31'h0, irqRequest}, 32'h1);
        wr(8'h0B, 8'h88);
        expect_reg(8'h0B, 32'h89);
        expect_reg(8'h40, 32'h06);
        wr(8'h0B, 8'h88);
        expect_reg(8'h0B, 32'h88);
        $display("test pin change done");
        wr(8'h0B, 8'hA4);
        for (int i = 0; i < 9; i++) begin
            slow <= i[0];
            acceptEn <= 1'b1;
            waitN = 0;
            @(posedge mclk);
            while (irqTaken !== 1'b1) begin
                waitN++;
                if (waitN > 20) begin
                    n_fail++;
                    tally_and_finish();
                end
                @(posedge mclk);
            end
            pushed[i] = pc;
            acceptEn <= 1'b0;
            tick(2);
            check({19'h0, stackTop}, {19'h0, pushed[i]});
        end
        for (int k = 1; k < 9; k++) begin
            stackPop <= 1'b1;
            @(posedge mclk);
            stackPop <= 1'b0;
            tick(1);
            check({19'h0, stackTop}, {19'h0, pushed[(k == 8) ? 8 : 8 - k]});
        end
        $display("test stack done");
        tally_and_finish();
    end
endmodule : mic_interrupt_control_bench
